//--- rtl/gppc_top.sv
// Pin control pair for port 5 bits 3 and 4, with AXI4-Lite register access.
// Assumes pin inputs are asynchronous; the board resolves pin level from enables.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module gppc_top (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic STANDBY_SUPPLY_POWER_ON_RESET,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic PORT5_BIT3_PIN_IN,
    output logic PORT5_BIT3_PIN_OUT,
    output logic PORT5_BIT3_PIN_OE_N,
    input wire logic PORT5_BIT4_PIN_IN,
    output logic PORT5_BIT4_PIN_OUT,
    output logic PORT5_BIT4_PIN_OE_N,
    input wire logic GPIO_OUT_BIT3,
    input wire logic GPIO_OUT_BIT4,
    input wire logic SECOND_SERIAL_TRANSMIT,
    output logic SECOND_SERIAL_SET_READY_N,
    output logic INTERRUPT_REQUEST_SEVEN,
    output logic INTERRUPT_REQUEST_NINE,
    output logic GPIO_IN_BIT3,
    output logic GPIO_IN_BIT4
);
    typedef struct packed {
        logic [7:0] pin3_reg;
        logic [7:0] pin4_reg;
        logic [1:0] sync3_reg;
        logic [1:0] sync4_reg;
        logic aw_reg;
        logic [3:0] awaddr_reg;
        logic w_reg;
        logic [7:0] wdata_reg;
        logic wstrb_reg;
        logic bvalid_reg;
        logic [1:0] bresp_reg;
        logic rvalid_reg;
        logic [31:0] rdata_reg;
        logic [1:0] rresp_reg;
        logic p3_out_reg;
        logic p3_oe_n_reg;
        logic p4_out_reg;
        logic p4_oe_n_reg;
        logic dsr_n_reg;
        logic interrupt_request_seven_reg;
        logic interrupt_request_nine_reg;
        logic in3_reg;
        logic in4_reg;
        logic awready_reg;
        logic wready_reg;
        logic arready_reg;
    } gppc_state_t;

    gppc_state_t st_reg;
    gppc_state_t st_next;
    logic [7:0] c3;
    logic [7:0] c4;
    logic pin3_v;
    logic pin4_v;
    logic drv3;
    logic drv4;

    always_comb begin
        st_next = st_reg;
        // Pin inputs: two sync stages, logic reads the second
        st_next.sync3_reg = {st_reg.sync3_reg[0], PORT5_BIT3_PIN_IN};
        st_next.sync4_reg = {st_reg.sync4_reg[0], PORT5_BIT4_PIN_IN};
        // Write channel capture, either order
        if (S_AXI_AWVALID && !st_reg.aw_reg && !st_reg.bvalid_reg) begin
            st_next.aw_reg = 1'b1;
            st_next.awaddr_reg = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !st_reg.w_reg && !st_reg.bvalid_reg) begin
            st_next.w_reg = 1'b1;
            st_next.wdata_reg = S_AXI_WDATA[7:0];
            st_next.wstrb_reg = S_AXI_WSTRB[0];
        end
        if (st_reg.aw_reg && st_reg.w_reg) begin
            st_next.aw_reg = 1'b0;
            st_next.w_reg = 1'b0;
            st_next.bvalid_reg = 1'b1;
            st_next.bresp_reg = gppc_pkg::RESP_OKAY;
            // Reserved bits never stored, so they read back zero
            if (st_reg.awaddr_reg == gppc_pkg::ADDR_PIN3) begin
                if (st_reg.wstrb_reg) begin
                    st_next.pin3_reg = st_reg.wdata_reg & gppc_pkg::WRITE_MASK;
                end
            end else if (st_reg.awaddr_reg == gppc_pkg::ADDR_PIN4) begin
                if (st_reg.wstrb_reg) begin
                    st_next.pin4_reg = st_reg.wdata_reg & gppc_pkg::WRITE_MASK;
                end
            end else if (st_reg.awaddr_reg != gppc_pkg::ADDR_PINS) begin
                st_next.bresp_reg = gppc_pkg::RESP_SLVERR;
            end
        end
        if (st_reg.bvalid_reg && S_AXI_BREADY) begin
            st_next.bvalid_reg = 1'b0;
        end
        // Read channel, one cycle answer
        if (S_AXI_ARVALID && !st_reg.rvalid_reg) begin
            st_next.rvalid_reg = 1'b1;
            st_next.rresp_reg = gppc_pkg::RESP_OKAY;
            case (S_AXI_ARADDR)
                gppc_pkg::ADDR_PIN3: st_next.rdata_reg = {24'h00_0000, st_reg.pin3_reg};
                gppc_pkg::ADDR_PIN4: st_next.rdata_reg = {24'h00_0000, st_reg.pin4_reg};
                gppc_pkg::ADDR_PINS: st_next.rdata_reg = {30'h0000_0000, st_reg.in4_reg, st_reg.in3_reg};
                default: begin
                    st_next.rdata_reg = 32'h0000_0000;
                    st_next.rresp_reg = gppc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st_reg.rvalid_reg && S_AXI_RREADY) begin
            st_next.rvalid_reg = 1'b0;
        end
        c3 = st_reg.pin3_reg;
        c4 = st_reg.pin4_reg;
        // Polarity applies both ways
        pin3_v = st_reg.sync3_reg[1] ^ c3[gppc_pkg::POL_BIT];
        pin4_v = st_reg.sync4_reg[1] ^ c4[gppc_pkg::POL_BIT];
        // Bit 3 pin: transmit out in alternate A, interrupt seven in B
        case (c3[gppc_pkg::FUN_LO+1:gppc_pkg::FUN_LO])
            gppc_pkg::FUN_ALT_A: drv3 = SECOND_SERIAL_TRANSMIT;
            default: drv3 = GPIO_OUT_BIT3;
        endcase
        case (c4[gppc_pkg::FUN_LO+1:gppc_pkg::FUN_LO])
            default: drv4 = GPIO_OUT_BIT4;
        endcase
        st_next.interrupt_request_seven_reg = (c3[3:2] == gppc_pkg::FUN_ALT_B) && pin3_v;
        // Bit 4 pin: interrupt nine or set-ready input
        st_next.interrupt_request_nine_reg = (c4[3:2] == gppc_pkg::FUN_ALT_B) && pin4_v;
        st_next.dsr_n_reg = (c4[3:2] == gppc_pkg::FUN_ALT_A) ? pin4_v : 1'b1;
        st_next.in3_reg = (c3[3:2] == gppc_pkg::FUN_GPIO) && pin3_v;
        st_next.in4_reg = (c4[3:2] == gppc_pkg::FUN_GPIO) && pin4_v;
        // Output value and enable; input direction floats the pin
        drv3 = drv3 ^ c3[gppc_pkg::POL_BIT];
        drv4 = drv4 ^ c4[gppc_pkg::POL_BIT];
        // Open drain drives only low
        st_next.p3_out_reg = c3[gppc_pkg::TYPE_BIT] ? 1'b0 : drv3;
        st_next.p4_out_reg = c4[gppc_pkg::TYPE_BIT] ? 1'b0 : drv4;
        st_next.p3_oe_n_reg = c3[gppc_pkg::DIR_BIT] || (c3[3:2] == 2'h3) || (c3[3:2] == gppc_pkg::FUN_ALT_B)
            || (c3[gppc_pkg::TYPE_BIT] && drv3);
        // Set-ready and interrupt nine are inputs, so alternates float the pin
        st_next.p4_oe_n_reg = c4[gppc_pkg::DIR_BIT] || (c4[3:2] != gppc_pkg::FUN_GPIO)
            || (c4[gppc_pkg::TYPE_BIT] && drv4);
        // Standby reset clears bit 3 and presets bit 4; hard reset only bit 3
        if (RST || STANDBY_SUPPLY_POWER_ON_RESET) begin
            st_next.pin3_reg = gppc_pkg::PIN3_RESET;
        end
        if (STANDBY_SUPPLY_POWER_ON_RESET) begin
            st_next.pin4_reg = gppc_pkg::PIN4_RESET;
        end
        // Readies registered so every port leaves a flop
        st_next.awready_reg = !st_next.aw_reg && !st_next.bvalid_reg;
        st_next.wready_reg = !st_next.w_reg && !st_next.bvalid_reg;
        st_next.arready_reg = !st_next.rvalid_reg;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_reg <= '0;
            st_reg.pin4_reg <= st_next.pin4_reg;
            st_reg.p3_oe_n_reg <= 1'b1;
            st_reg.p4_oe_n_reg <= 1'b1;
            st_reg.dsr_n_reg <= 1'b1;
            st_reg.awready_reg <= 1'b1;
            st_reg.wready_reg <= 1'b1;
            st_reg.arready_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign S_AXI_AWREADY = st_reg.awready_reg;
    assign S_AXI_WREADY = st_reg.wready_reg;
    assign S_AXI_BVALID = st_reg.bvalid_reg;
    assign S_AXI_BRESP = st_reg.bresp_reg;
    assign S_AXI_ARREADY = st_reg.arready_reg;
    assign S_AXI_RVALID = st_reg.rvalid_reg;
    assign S_AXI_RDATA = st_reg.rdata_reg;
    assign S_AXI_RRESP = st_reg.rresp_reg;
    assign PORT5_BIT3_PIN_OUT = st_reg.p3_out_reg;
    assign PORT5_BIT3_PIN_OE_N = st_reg.p3_oe_n_reg;
    assign PORT5_BIT4_PIN_OUT = st_reg.p4_out_reg;
    assign PORT5_BIT4_PIN_OE_N = st_reg.p4_oe_n_reg;
    assign SECOND_SERIAL_SET_READY_N = st_reg.dsr_n_reg;
    assign INTERRUPT_REQUEST_SEVEN = st_reg.interrupt_request_seven_reg;
    assign INTERRUPT_REQUEST_NINE = st_reg.interrupt_request_nine_reg;
    assign GPIO_IN_BIT3 = st_reg.in3_reg;
    assign GPIO_IN_BIT4 = st_reg.in4_reg;

    a_reserved_read_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
        (st_reg.pin3_reg & ~gppc_pkg::WRITE_MASK) == 8'h00 && (st_reg.pin4_reg & ~gppc_pkg::WRITE_MASK) == 8'h00)
        else $error("reserved bits set");
    a_input_floats_pin: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg[0] |=> st_reg.p3_oe_n_reg)
        else $error("bit 3 pin driven while input");
    a_open_drain_low: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg[7] |=> !st_reg.p3_out_reg)
        else $error("open drain drove high");
    a_push_pull_value: assert property (@(posedge SYS_CLK) disable iff (RST)
        (st_reg.pin3_reg == 8'h00 && $stable(st_reg.pin3_reg)) |=> (st_reg.p3_out_reg == $past(GPIO_OUT_BIT3)))
        else $error("push pull value wrong");
    a_irq_seven_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg[3:2] != gppc_pkg::FUN_ALT_B |=> !st_reg.interrupt_request_seven_reg)
        else $error("interrupt seven outside its function");
    a_irq_nine_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin4_reg[3:2] != gppc_pkg::FUN_ALT_B |=> !st_reg.interrupt_request_nine_reg)
        else $error("interrupt nine outside its function");
    a_reserved_code_float: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg[3:2] == 2'h3 |=> st_reg.p3_oe_n_reg)
        else $error("reserved function drove pin");
    a_standby_preset: assert property (@(posedge SYS_CLK)
        STANDBY_SUPPLY_POWER_ON_RESET |=> st_reg.pin4_reg == gppc_pkg::PIN4_RESET && st_reg.pin3_reg == 8'h00)
        else $error("standby reset values wrong");
    a_pin4_input_float: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin4_reg[0] |=> st_reg.p4_oe_n_reg)
        else $error("bit 4 pin driven while input");
    a_pin4_open_drain: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin4_reg[7] |=> !st_reg.p4_out_reg)
        else $error("bit 4 open drain drove high");
    a_pin4_alt_float: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin4_reg[3:2] != gppc_pkg::FUN_GPIO |=> st_reg.p4_oe_n_reg)
        else $error("bit 4 alternate drove pin");
    a_pin3_irq_float: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg[3:2] == gppc_pkg::FUN_ALT_B |=> st_reg.p3_oe_n_reg)
        else $error("bit 3 interrupt input drove pin");
    a_transmit_drives: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg == 8'h04 |=> !st_reg.p3_oe_n_reg)
        else $error("transmit function left pin floating");
    a_transmit_route: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg == 8'h04 |=> st_reg.p3_out_reg == $past(SECOND_SERIAL_TRANSMIT))
        else $error("transmit value not on pin");
    a_set_ready_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin4_reg[3:2] != gppc_pkg::FUN_ALT_A |=> st_reg.dsr_n_reg)
        else $error("set ready active outside its function");
    a_set_ready_value: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin4_reg[3:2] == gppc_pkg::FUN_ALT_A
        |=> st_reg.dsr_n_reg == ($past(st_reg.sync4_reg[1]) ^ $past(st_reg.pin4_reg[1])))
        else $error("set ready value wrong");
    a_irq_seven_value: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg[3:2] == gppc_pkg::FUN_ALT_B
        |=> st_reg.interrupt_request_seven_reg == ($past(st_reg.sync3_reg[1]) ^ $past(st_reg.pin3_reg[1])))
        else $error("interrupt seven value wrong");
    a_irq_nine_value: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin4_reg[3:2] == gppc_pkg::FUN_ALT_B
        |=> st_reg.interrupt_request_nine_reg == ($past(st_reg.sync4_reg[1]) ^ $past(st_reg.pin4_reg[1])))
        else $error("interrupt nine value wrong");
    a_gpio_in_gate3: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg[3:2] != gppc_pkg::FUN_GPIO |=> !st_reg.in3_reg)
        else $error("bit 3 input shown outside plain function");
    a_gpio_in_gate4: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin4_reg[3:2] != gppc_pkg::FUN_GPIO |=> !st_reg.in4_reg)
        else $error("bit 4 input shown outside plain function");
    a_in_polarity3: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin3_reg[3:2] == gppc_pkg::FUN_GPIO
        |=> st_reg.in3_reg == ($past(st_reg.sync3_reg[1]) ^ $past(st_reg.pin3_reg[1])))
        else $error("bit 3 input polarity wrong");
    a_in_polarity4: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_reg.pin4_reg[3:2] == gppc_pkg::FUN_GPIO
        |=> st_reg.in4_reg == ($past(st_reg.sync4_reg[1]) ^ $past(st_reg.pin4_reg[1])))
        else $error("bit 4 input polarity wrong");
    a_out_polarity3: assert property (@(posedge SYS_CLK) disable iff (RST)
        (st_reg.pin3_reg[3:2] == gppc_pkg::FUN_GPIO && !st_reg.pin3_reg[7])
        |=> st_reg.p3_out_reg == ($past(GPIO_OUT_BIT3) ^ $past(st_reg.pin3_reg[1])))
        else $error("bit 3 output polarity wrong");
    a_out_polarity4: assert property (@(posedge SYS_CLK) disable iff (RST)
        (st_reg.pin4_reg[3:2] == gppc_pkg::FUN_GPIO && !st_reg.pin4_reg[7])
        |=> st_reg.p4_out_reg == ($past(GPIO_OUT_BIT4) ^ $past(st_reg.pin4_reg[1])))
        else $error("bit 4 output polarity wrong");
    a_push_pull_drive4: assert property (@(posedge SYS_CLK) disable iff (RST)
        (st_reg.pin4_reg[3:2] == gppc_pkg::FUN_GPIO && !st_reg.pin4_reg[0] && !st_reg.pin4_reg[7])
        |=> !st_reg.p4_oe_n_reg)
        else $error("bit 4 push pull output not driven");
    a_hard_reset_clear: assert property (@(posedge SYS_CLK)
        RST |=> st_reg.pin3_reg == gppc_pkg::PIN3_RESET)
        else $error("hard reset left bit 3 register set");
    a_hard_reset_keeps: assert property (@(posedge SYS_CLK)
        (RST && !STANDBY_SUPPLY_POWER_ON_RESET) |=> $stable(st_reg.pin4_reg))
        else $error("hard reset changed bit 4 register");
    a_bvalid_holds: assert property (@(posedge SYS_CLK) disable iff (RST)
        (st_reg.bvalid_reg && !S_AXI_BREADY) |=> st_reg.bvalid_reg)
        else $error("write response dropped early");
    a_rvalid_holds: assert property (@(posedge SYS_CLK) disable iff (RST)
        (st_reg.rvalid_reg && !S_AXI_RREADY) |=> st_reg.rvalid_reg && $stable(st_reg.rdata_reg))
        else $error("read response dropped early");
    a_write_lands3: assert property (@(posedge SYS_CLK) disable iff (RST)
        (st_reg.aw_reg && st_reg.w_reg && st_reg.wstrb_reg && st_reg.awaddr_reg == gppc_pkg::ADDR_PIN3
        && !STANDBY_SUPPLY_POWER_ON_RESET) |=> st_reg.pin3_reg == ($past(st_reg.wdata_reg) & gppc_pkg::WRITE_MASK))
        else $error("bit 3 register write lost");
endmodule
`default_nettype wire

//--- rtl/gppc_pkg.sv
// Constants for the port 5 pin control pair: offsets, fields, reset values.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package gppc_pkg;
    localparam logic [3:0] ADDR_PIN3 = 4'h0;
    localparam logic [3:0] ADDR_PIN4 = 4'h4;
    localparam logic [3:0] ADDR_PINS = 4'h8;
    localparam int DIR_BIT = 0;
    localparam int POL_BIT = 1;
    localparam int FUN_LO = 2;
    localparam int TYPE_BIT = 7;
    localparam logic [7:0] WRITE_MASK = 8'h8F;
    localparam logic [7:0] PIN3_RESET = 8'h00;
    localparam logic [7:0] PIN4_RESET = 8'h01;
    localparam logic [1:0] FUN_GPIO = 2'h0;
    localparam logic [1:0] FUN_ALT_A = 2'h1;
    localparam logic [1:0] FUN_ALT_B = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- verification/gppc_board.sv
// Board model of one multiplexed pin: resolves the wire level.
// Assumes the design's enable is low while it drives the pin.
`timescale 1ns/1ps
`default_nettype none
module gppc_board (
    input wire logic out,
    input wire logic oe_n,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pin
);
    // Pull-up holds a released wire, so open drain reads high
    always_comb begin
        if (!oe_n) begin
            pin = out;
        end else if (ext_en) begin
            pin = ext_val;
        end else begin
            pin = 1'h1;
        end
    end
endmodule
`default_nettype wire

//--- verification/tb.sv
// Bench for the pin control pair: AXI4-Lite tasks, board pins, checks.
// Assumes the hand-over latencies; pin paths get five cycles to settle.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic sby = 1'h1;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic go3 = 1'h0, go4 = 1'h0, tx = 1'h1, e3 = 1'h0, v3 = 1'h0, e4 = 1'h0, v4 = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rr, br;
    logic [31:0] rdata, rdat;
    logic p3, p3_out, p3_oe_n, p4, p4_out, p4_oe_n, srn, interrupt_request_seven, interrupt_request_nine, gin3, gin4;
    int bad_count = 0;
    int tests_run = 0;
    gppc_top gppc_top_i (.SYS_CLK(clk), .RST(rst), .STANDBY_SUPPLY_POWER_ON_RESET(sby),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PORT5_BIT3_PIN_IN(p3), .PORT5_BIT3_PIN_OUT(p3_out), .PORT5_BIT3_PIN_OE_N(p3_oe_n),
        .PORT5_BIT4_PIN_IN(p4), .PORT5_BIT4_PIN_OUT(p4_out), .PORT5_BIT4_PIN_OE_N(p4_oe_n),
        .GPIO_OUT_BIT3(go3), .GPIO_OUT_BIT4(go4), .SECOND_SERIAL_TRANSMIT(tx),
        .SECOND_SERIAL_SET_READY_N(srn), .INTERRUPT_REQUEST_SEVEN(interrupt_request_seven),
        .INTERRUPT_REQUEST_NINE(interrupt_request_nine), .GPIO_IN_BIT3(gin3), .GPIO_IN_BIT4(gin4));
    gppc_board board3_i (.out(p3_out), .oe_n(p3_oe_n), .ext_en(e3), .ext_val(v3), .pin(p3));
    gppc_board board4_i (.out(p4_out), .oe_n(p4_oe_n), .ext_en(e4), .ext_val(v4), .pin(p4));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask
    // Bounded waits only; a hung handshake ends the run
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) begin
                br = bresp;
                bready <= 1'h0;
                break;
            end
        end
        if (n == 100) begin
            check(32'h0000_0000, 32'h0000_0001);
            end_of_test;
        end
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) begin
                rdat = rdata;
                rr = rresp;
                rready <= 1'h0;
                break;
            end
        end
        if (n == 100) begin
            check(32'h0000_0000, 32'h0000_0001);
            end_of_test;
        end
    endtask
    task automatic settle;
        repeat (5) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        sby <= 1'h0;
        rd(gppc_pkg::ADDR_PIN3);
        check(rdat, 32'h0000_0000);
        rd(gppc_pkg::ADDR_PIN4);
        check(rdat, 32'h0000_0001);
        wr(gppc_pkg::ADDR_PIN3, 32'h0000_00FF);
        check(32'(br), 32'(gppc_pkg::RESP_OKAY));
        rd(gppc_pkg::ADDR_PIN3);
        check(rdat, 32'h0000_008F);
        wstrb <= 4'h0;
        wr(gppc_pkg::ADDR_PIN3, 32'h0000_0000);
        wstrb <= 4'hF;
        rd(gppc_pkg::ADDR_PIN3);
        check(rdat, 32'h0000_008F);
        rd(4'hC);
        check(32'(rr), 32'(gppc_pkg::RESP_SLVERR));
        wr(gppc_pkg::ADDR_PIN3, 32'h0000_0000);
        go3 <= 1'h1;
        settle;
        check(32'(p3_oe_n), 32'h0000_0000);
        check(32'(p3), 32'h0000_0001);
        wr(gppc_pkg::ADDR_PIN3, 32'h0000_0002);
        settle;
        check(32'(p3), 32'h0000_0000);
        wr(gppc_pkg::ADDR_PIN3, 32'h0000_0080);
        settle;
        check(32'(p3_oe_n), 32'h0000_0001);
        check(32'(p3), 32'h0000_0001);
        go3 <= 1'h0;
        settle;
        check(32'(p3_oe_n), 32'h0000_0000);
        check(32'(p3), 32'h0000_0000);
        wr(gppc_pkg::ADDR_PIN3, 32'h0000_0001);
        e3 <= 1'h1;
        settle;
        check(32'(p3_oe_n), 32'h0000_0001);
        check(32'(gin3), 32'h0000_0000);
        wr(gppc_pkg::ADDR_PIN3, 32'h0000_0003);
        settle;
        check(32'(gin3), 32'h0000_0001);
        wr(gppc_pkg::ADDR_PIN3, 32'h0000_0009);
        v3 <= 1'h1;
        settle;
        check(32'(interrupt_request_seven), 32'h0000_0001);
        check(32'(gin3), 32'h0000_0000);
        v3 <= 1'h0;
        settle;
        check(32'(interrupt_request_seven), 32'h0000_0000);
        e3 <= 1'h0;
        wr(gppc_pkg::ADDR_PIN3, 32'h0000_0004);
        tx <= 1'h0;
        settle;
        check(32'(p3), 32'h0000_0000);
        tx <= 1'h1;
        settle;
        check(32'(p3), 32'h0000_0001);
        e4 <= 1'h1;
        v4 <= 1'h1;
        wr(gppc_pkg::ADDR_PIN4, 32'h0000_0009);
        settle;
        check(32'(interrupt_request_nine), 32'h0000_0001);
        check(32'(p4_oe_n), 32'h0000_0001);
        v4 <= 1'h0;
        settle;
        check(32'(interrupt_request_nine), 32'h0000_0000);
        wr(gppc_pkg::ADDR_PIN4, 32'h0000_0005);
        settle;
        check(32'(srn), 32'h0000_0000);
        v4 <= 1'h1;
        settle;
        check(32'(srn), 32'h0000_0001);
        wr(gppc_pkg::ADDR_PIN4, 32'h0000_0001);
        settle;
        check(32'(gin4), 32'h0000_0001);
        check(32'(srn), 32'h0000_0001);
        rd(gppc_pkg::ADDR_PINS);
        check(rdat, 32'h0000_0002);
        e4 <= 1'h0;
        wr(gppc_pkg::ADDR_PIN4, 32'h0000_0000);
        go4 <= 1'h1;
        settle;
        check(32'(p4_oe_n), 32'h0000_0000);
        check(32'(p4), 32'h0000_0001);
        check(32'(p4_out), 32'h0000_0001);
        wr(gppc_pkg::ADDR_PIN4, 32'h0000_0005);
        @(posedge clk);
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        rd(gppc_pkg::ADDR_PIN3);
        check(rdat, 32'h0000_0000);
        rd(gppc_pkg::ADDR_PIN4);
        check(rdat, 32'h0000_0005);
        @(posedge clk);
        sby <= 1'h1;
        @(posedge clk);
        sby <= 1'h0;
        rd(gppc_pkg::ADDR_PIN4);
        check(rdat, 32'h0000_0001);
        end_of_test;
    end
endmodule
`default_nettype wire
